//--- hdl/plc_gpio_cfg.v
`timescale 1ns/10ps
`include "plc_consts.vh"

module plc_gpio_cfg (
  // clock and reset
  input  wire        clk_sys_i,
  input  wire        rst_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [7:0]  wr_data_i,
  input  wire        wr_i,
  input  wire        rd_i,
  output reg  [7:0]  rd_data_o,
  // supply resets, synchronous levels
  input  wire        vdd_rst_i,
  input  wire        vsb_rst_i,
  // pads, index port*8+pin
  output wire [55:0] pad_o,
  output wire [55:0] pad_oe_n_o,
  output wire [55:0] pullup_en_o,
  // event controls, port 4 high byte, port 1 low byte
  output wire [15:0] ev_debounce_o,
  output wire [15:0] ev_polarity_o,
  output wire [15:0] ev_level_o
);

  // number of pins on a port
  function integer port_width;
    input integer port;
    begin
      case (port)
        0, 1, 2, 3, 4: port_width = 8;
        5:             port_width = 6;
        6:             port_width = 5;
        default:       port_width = 0;
      endcase
    end
  endfunction

  // pull-up reset per pin, code is port*10+pin
  function pu_reset;
    input integer code;
    begin
      pu_reset = ((code >= 20) && (code <= 21)) || ((code >= 26) && (code <= 27)) ||
                 ((code >= 30) && (code <= 37)) || ((code >= 40) && (code <= 42)) ||
                 ((code >= 51) && (code <= 53)) || (code == 64);
    end
  endfunction

  function pin_exists;
    input [2:0] port;
    input [2:0] pin;
    begin
      pin_exists = ({29'h0, pin} < port_width({29'h0, port}));
    end
  endfunction

  // register map decode, shared by the write strobes and the read mux
  localparam [2:0] REG_NONE = 3'h0;
  localparam [2:0] REG_SEL  = 3'h1;
  localparam [2:0] REG_CFG1 = 3'h2;
  localparam [2:0] REG_CFG2 = 3'h3;
  localparam [2:0] REG_LOCK = 3'h4;
  localparam [2:0] REG_DOUT = 3'h5;

  function [2:0] reg_decode;
    input [7:0] addr;
    begin
      case (addr)
        `PLC_OFF_PIN_SELECT:  reg_decode = REG_SEL;
        `PLC_OFF_PIN_CFG_ONE: reg_decode = REG_CFG1;
        `PLC_OFF_PIN_CFG_TWO: reg_decode = REG_CFG2;
        `PLC_OFF_LOCK_CTL:    reg_decode = REG_LOCK;
        default: begin
          if ((addr >= `PLC_OFF_DOUT_BASE) && (addr <= `PLC_OFF_DOUT_LAST)) begin
            reg_decode = REG_DOUT;
          end else begin
            reg_decode = REG_NONE;
          end
        end
      endcase
    end
  endfunction

  reg  [7:0] pin_select_q;
  reg  [7:0] lock_ctl_q;
  reg  [7:0] rd_d;

  wire [2:0] sel_port_w = pin_select_q[`PLC_SEL_PORT_MSB:`PLC_SEL_PORT_LSB];
  wire [2:0] sel_pin_w  = pin_select_q[`PLC_SEL_PIN_MSB:`PLC_SEL_PIN_LSB];
  wire [5:0] sel_idx_w  = {sel_port_w, sel_pin_w};
  wire       sel_ok_w   = pin_exists(sel_port_w, sel_pin_w);
  wire [2:0] reg_w       = reg_decode(addr_i);
  wire [2:0] dout_port_w = addr_i[2:0];

  wire       wr_sel_w  = wr_i && (reg_w == REG_SEL);
  wire       wr_lock_w = wr_i && (reg_w == REG_LOCK);
  wire       wr_cfg1_w = wr_i && (reg_w == REG_CFG1) && sel_ok_w;
  wire       wr_cfg2_w = wr_i && (reg_w == REG_CFG2) && sel_ok_w;
  wire       wr_dout_w = wr_i && (reg_w == REG_DOUT);

  // lock release: chosen supply reset or global unlock
  wire       lock_clr_w = lock_ctl_q[`PLC_BIT_GLOBAL_UNLOCK] |
                          (lock_ctl_q[`PLC_BIT_LOCK_SCOPE] ? vsb_rst_i : vdd_rst_i);

  wire [7:0]  cfg1_w [0:55];
  wire [7:0]  cfg2_w [0:55];
  wire [55:0] dout_w;
  wire [55:0] ev_dbnc_w;
  wire [55:0] ev_pol_w;
  wire [55:0] ev_type_w;

  // one output data write strobe and one readback byte per port
  wire [`PLC_NUM_PORTS-1:0] dout_port_wr_w;
  wire [7:0]                dout_byte_w [0:`PLC_NUM_PORTS-1];

  genvar gq;
  generate
    for (gq = 0; gq < `PLC_NUM_PORTS; gq = gq + 1) begin : g_port_bus
      assign dout_port_wr_w[gq] = wr_dout_w && (dout_port_w == gq);
      assign dout_byte_w[gq]    = dout_w[gq * 8 +: 8];
    end
  endgenerate

  genvar gp;
  genvar gn;
  generate
    for (gp = 0; gp < `PLC_NUM_PORTS + 1; gp = gp + 1) begin : g_port
      for (gn = 0; gn < 8; gn = gn + 1) begin : g_pin
        if ((gp < `PLC_NUM_PORTS) && (gn < port_width(gp))) begin : g_real
          localparam [0:0] EVC = ((gp == `PLC_EV_PORT_A) || (gp == `PLC_EV_PORT_B)) ? 1'b1 : 1'b0;
          wire       hit_w = (sel_idx_w == gp * 8 + gn);
          wire [2:0] evo_w;
          plc_pin_cell #(
            .EV_CAP (EVC),
            .PU_RST (pu_reset(gp * 10 + gn))
          ) u_cell (
            .clk_sys_i  (clk_sys_i),
            .rst_i      (rst_i),
            .cfg1_wr_i  (wr_cfg1_w && hit_w),
            .cfg2_wr_i  (wr_cfg2_w && hit_w),
            .dout_wr_i  (dout_port_wr_w[gp]),
            .wdata_i    (wr_data_i),
            .dout_bit_i (wr_data_i[gn]),
            .lock_clr_i (lock_clr_w),
            .cfg1_o     (cfg1_w[gp * 8 + gn]),
            .cfg2_o     (cfg2_w[gp * 8 + gn]),
            .dout_o     (dout_w[gp * 8 + gn])
          );
          plc_pad_drive #(
            .HOLD_PU    ((gp * 10 + gn) == 64)
          ) u_drive (
            .clk_sys_i  (clk_sys_i),
            .rst_i      (rst_i),
            .cfg1_i     (cfg1_w[gp * 8 + gn]),
            .dout_i     (dout_w[gp * 8 + gn]),
            .vsb_rst_i  (vsb_rst_i),
            .pad_o      (pad_o[gp * 8 + gn]),
            .pad_oe_n_o (pad_oe_n_o[gp * 8 + gn]),
            .pullup_o   (pullup_en_o[gp * 8 + gn]),
            .ev_o       (evo_w)
          );
          assign ev_dbnc_w[gp * 8 + gn] = evo_w[2];
          assign ev_pol_w[gp * 8 + gn]  = evo_w[1];
          assign ev_type_w[gp * 8 + gn] = evo_w[0];
        end else if (gp < `PLC_NUM_PORTS) begin : g_absent
          // no pad behind this slot, pad outputs parked in flops
          reg pad_q;
          reg pad_oe_n_q;
          reg pullup_q;
          always @(posedge clk_sys_i or posedge rst_i) begin
            if (rst_i) begin
              pad_q      <= 1'b0;
              pad_oe_n_q <= 1'b1;
              pullup_q   <= 1'b0;
            end else begin
              pad_q      <= 1'b0;
              pad_oe_n_q <= 1'b1;
              pullup_q   <= 1'b0;
            end
          end
          assign cfg1_w[gp * 8 + gn]      = 8'h00;
          assign cfg2_w[gp * 8 + gn]      = 8'h00;
          assign dout_w[gp * 8 + gn]      = 1'b0;
          assign pad_o[gp * 8 + gn]       = pad_q;
          assign pad_oe_n_o[gp * 8 + gn]  = pad_oe_n_q;
          assign pullup_en_o[gp * 8 + gn] = pullup_q;
          assign ev_dbnc_w[gp * 8 + gn]   = 1'b0;
          assign ev_pol_w[gp * 8 + gn]    = 1'b0;
          assign ev_type_w[gp * 8 + gn]   = 1'b0;
        end
      end
    end
  endgenerate

  // event controls exist on the two event-capable ports only
  generate
    for (gq = 0; gq < 8; gq = gq + 1) begin : g_ev_map
      assign ev_debounce_o[gq]     = ev_dbnc_w[`PLC_EV_PORT_A * 8 + gq];
      assign ev_debounce_o[gq + 8] = ev_dbnc_w[`PLC_EV_PORT_B * 8 + gq];
      assign ev_polarity_o[gq]     = ev_pol_w[`PLC_EV_PORT_A * 8 + gq];
      assign ev_polarity_o[gq + 8] = ev_pol_w[`PLC_EV_PORT_B * 8 + gq];
      assign ev_level_o[gq]        = ev_type_w[`PLC_EV_PORT_A * 8 + gq];
      assign ev_level_o[gq + 8]    = ev_type_w[`PLC_EV_PORT_B * 8 + gq];
    end
  endgenerate

  // control registers
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_select_q <= `PLC_SEL_RST;
      lock_ctl_q   <= `PLC_LOCK_CTL_RST;
    end else begin
      if (wr_sel_w) begin
        pin_select_q <= wr_data_i & `PLC_SEL_MASK;
      end
      if (wr_lock_w) begin
        lock_ctl_q <= wr_data_i & `PLC_LOCK_CTL_MASK;
      end
    end
  end

  // read data, valid the cycle after the strobe
  always @* begin
    rd_d = `PLC_RD_IDLE;
    case (reg_w)
      REG_SEL:  rd_d = pin_select_q;
      REG_CFG1: rd_d = sel_ok_w ? cfg1_w[sel_idx_w] : 8'h00;
      REG_CFG2: rd_d = sel_ok_w ? cfg2_w[sel_idx_w] : 8'h00;
      REG_LOCK: rd_d = lock_ctl_q;
      REG_DOUT: rd_d = dout_byte_w[dout_port_w];
      default:  rd_d = `PLC_RD_IDLE;
    endcase
  end

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= `PLC_RD_IDLE;
    end else begin
      rd_data_o <= rd_i ? rd_d : `PLC_RD_IDLE;
    end
  end

endmodule // plc_gpio_cfg

//--- hdl/plc_consts.vh
`ifndef PLC_CONSTS_VH
`define PLC_CONSTS_VH

// register offsets on the configuration port
`define PLC_OFF_PIN_SELECT    8'h00
`define PLC_OFF_PIN_CFG_ONE   8'h01
`define PLC_OFF_PIN_CFG_TWO   8'h03
`define PLC_OFF_LOCK_CTL      8'h04
`define PLC_OFF_DOUT_BASE     8'h10
`define PLC_OFF_DOUT_LAST     8'h16

// geometry
`define PLC_NUM_PORTS         7
`define PLC_NUM_SLOTS         56
`define PLC_EV_PORT_A         1
`define PLC_EV_PORT_B         4

// pin_config_one fields
`define PLC_BIT_OUT_ENA       0
`define PLC_BIT_PUSH_PULL     1
`define PLC_BIT_PULLUP        2
`define PLC_BIT_LOCK          3
`define PLC_BIT_EV_TYPE       4
`define PLC_BIT_EV_POL        5
`define PLC_BIT_EV_DBNC       6

// pin_select fields
`define PLC_SEL_PORT_MSB      6
`define PLC_SEL_PORT_LSB      4
`define PLC_SEL_PIN_MSB       2
`define PLC_SEL_PIN_LSB       0
`define PLC_SEL_MASK          8'h77

// serial_bus_lock_control fields
`define PLC_BIT_LOCK_SCOPE    0
`define PLC_BIT_GLOBAL_UNLOCK 1
`define PLC_LOCK_CTL_MASK     8'h03

// pin_config_two writable field (bits 6-4)
`define PLC_CFG2_MSB          6
`define PLC_CFG2_LSB          4

// reset values
`define PLC_SEL_RST           8'h00
`define PLC_LOCK_CTL_RST      8'h00
`define PLC_EV_RST            3'h4
`define PLC_EV_NONE           3'h0
`define PLC_CFG2_RST          3'h0
`define PLC_RD_IDLE           8'h00

`endif

//--- hdl/plc_pin_cell.v
`timescale 1ns/10ps
`include "plc_consts.vh"

module plc_pin_cell #(
  parameter [0:0] EV_CAP = 1'b0,
  parameter [0:0] PU_RST = 1'b0
) (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_i,
  // write strobes for this pin
  input  wire       cfg1_wr_i,
  input  wire       cfg2_wr_i,
  input  wire       dout_wr_i,
  input  wire [7:0] wdata_i,
  input  wire       dout_bit_i,
  // lock release
  input  wire       lock_clr_i,
  // state
  output wire [7:0] cfg1_o,
  output wire [7:0] cfg2_o,
  output wire       dout_o
);

  reg [2:0] ev_q;
  reg       lock_q;
  reg       pu_q;
  reg       pp_q;
  reg       oe_q;
  reg [2:0] cfg2_q;
  reg       dout_q;

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ev_q   <= EV_CAP ? `PLC_EV_RST : `PLC_EV_NONE;
      lock_q <= 1'b0;
      pu_q   <= PU_RST;
      pp_q   <= 1'b0;
      oe_q   <= 1'b0;
      cfg2_q <= `PLC_CFG2_RST;
      dout_q <= 1'b0;
    end else begin
      // release wins over a same-cycle set
      if (lock_clr_i) begin
        lock_q <= 1'b0;
      end else if (cfg1_wr_i && wdata_i[`PLC_BIT_LOCK]) begin
        lock_q <= 1'b1;
      end
      if (cfg1_wr_i && EV_CAP) begin
        ev_q <= wdata_i[`PLC_BIT_EV_DBNC:`PLC_BIT_EV_TYPE];
      end
      if (cfg1_wr_i && !lock_q) begin
        pu_q <= wdata_i[`PLC_BIT_PULLUP];
        pp_q <= wdata_i[`PLC_BIT_PUSH_PULL];
        oe_q <= wdata_i[`PLC_BIT_OUT_ENA];
      end
      if (cfg2_wr_i && !lock_q) begin
        cfg2_q <= wdata_i[`PLC_CFG2_MSB:`PLC_CFG2_LSB];
      end
      if (dout_wr_i && !lock_q) begin
        dout_q <= dout_bit_i;
      end
    end
  end

  // reserved bits read zero
  assign cfg1_o = {1'b0, (EV_CAP ? ev_q : `PLC_EV_NONE), lock_q, pu_q, pp_q, oe_q};
  assign cfg2_o = {1'b0, cfg2_q, 4'h0};
  assign dout_o = dout_q;

endmodule // plc_pin_cell

//--- hdl/plc_pad_drive.v
`timescale 1ns/10ps
`include "plc_consts.vh"

module plc_pad_drive #(
  parameter [0:0] HOLD_PU = 1'b0
) (
  // clock and reset
  input  wire       clk_sys_i,
  input  wire       rst_i,
  // pin state
  input  wire [7:0] cfg1_i,
  input  wire       dout_i,
  input  wire       vsb_rst_i,
  // pad and event controls
  output reg        pad_o,
  output reg        pad_oe_n_o,
  output reg        pullup_o,
  output reg  [2:0] ev_o
);

  wire pp_w = cfg1_i[`PLC_BIT_PUSH_PULL];
  wire oe_w = cfg1_i[`PLC_BIT_OUT_ENA];

  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pad_o      <= 1'b0;
      pad_oe_n_o <= 1'b1;
      pullup_o   <= 1'b0;
      ev_o       <= `PLC_EV_NONE;
    end else begin
      // open-drain only ever drives low
      pad_o      <= pp_w & dout_i;
      pad_oe_n_o <= ~(oe_w & (pp_w | ~dout_i));
      pullup_o   <= cfg1_i[`PLC_BIT_PULLUP] & ~(HOLD_PU & vsb_rst_i);
      ev_o       <= cfg1_i[`PLC_BIT_EV_DBNC:`PLC_BIT_EV_TYPE];
    end
  end

endmodule // plc_pad_drive

//--- testbench/plc_gpio_cfg_properties.sv
`timescale 1ns/10ps
module plc_chk (
  // clock and reset
  input wire        clk_sys_i,
  input wire        rst_i,
  // register port
  input wire [7:0]  addr_i,
  input wire [7:0]  wr_data_i,
  input wire        wr_i,
  input wire        rd_i,
  input wire [7:0]  rd_data_o,
  // supply resets
  input wire        vdd_rst_i,
  input wire        vsb_rst_i,
  // pads and events
  input wire [55:0] pad_o,
  input wire [55:0] pad_oe_n_o,
  input wire [55:0] pullup_en_o,
  input wire [15:0] ev_debounce_o,
  input wire [15:0] ev_polarity_o,
  input wire [15:0] ev_level_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  rd_idle_a:
    assert property (!rd_i |=> rd_data_o == 8'h00) else $error("read data not idle");
  sel_resv_a:
    assert property (rd_i && addr_i == 8'h00 |=> (rd_data_o & 8'h88) == 8'h00) else $error("select reserved");
  cfg_top_a:
    assert property (rd_i && addr_i == 8'h01 |=> !rd_data_o[7]) else $error("config bit 7 set");
  cfg2_resv_a:
    assert property (rd_i && addr_i == 8'h03 |=> (rd_data_o & 8'h8F) == 8'h00) else $error("config two reserved");
  unmapped_zero_a:
    assert property (rd_i && addr_i inside {8'h02, [8'h05:8'h0F], [8'h17:8'hFF]} |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
  pin64_pu_a:
    assert property (vsb_rst_i |=> !pullup_en_o[52]) else $error("pin 64 pull-up on");
  rst_pullup_a:
    assert property ($fell(rst_i) && !vsb_rst_i |-> ##1 pullup_en_o == 56'h100E07FFC30000)
      else $error("pull-up reset pattern");
  rst_event_a:
    assert property ($fell(rst_i) |-> ##1 ev_debounce_o == 16'hFFFF && ev_polarity_o == 16'h0000
      && ev_level_o == 16'h0000 && &pad_oe_n_o) else $error("event reset pattern");
  ghost_pin_a:
    assert property (pad_oe_n_o[47:46] == 2'h3 && pad_oe_n_o[55:53] == 3'h7 && pad_o[47:46] == 2'h0
      && pad_o[55:53] == 3'h0) else $error("absent pin driven");
endmodule // plc_chk
bind plc_gpio_cfg plc_chk u_chk (.*);

//--- testbench/plc_load_model.sv
`timescale 1ns/10ps
module plc_load_model (
  // pad side of the block
  input  wire [55:0] pad_i,
  input  wire [55:0] pad_oe_n_i,
  input  wire [55:0] pullup_en_i,
  // level seen on each pin
  output wire [55:0] pin_lvl_o
);
  // weak external pull-down, loses to the internal pull-up
  assign pin_lvl_o = (~pad_oe_n_i & pad_i) | (pad_oe_n_i & pullup_en_i);
endmodule // plc_load_model

//--- testbench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  localparam [55:0] PU_RST = 56'h100E07FFC30000;
  reg         clk_sys_i = 1'b0;
  reg         rst_i = 1'b1;
  reg  [7:0]  addr_i = 8'h00;
  reg  [7:0]  wr_data_i = 8'h00;
  reg         wr_i = 1'b0;
  reg         rd_i = 1'b0;
  reg         vdd_rst_i = 1'b0;
  reg         vsb_rst_i = 1'b0;
  wire [7:0]  rd_data_o;
  wire [55:0] pad_o, pad_oe_n_o, pullup_en_o, pin_lvl;
  wire [15:0] ev_debounce_o, ev_polarity_o, ev_level_o;
  integer     mismatches = 0;
  integer     samples_checked = 0;
  integer     cycles = 0;
  integer     p, n, i, k, x;
  reg  [7:0]  d, w, e;

  plc_gpio_cfg u_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o), .vdd_rst_i(vdd_rst_i), .vsb_rst_i(vsb_rst_i),
    .pad_o(pad_o), .pad_oe_n_o(pad_oe_n_o), .pullup_en_o(pullup_en_o), .ev_debounce_o(ev_debounce_o),
    .ev_polarity_o(ev_polarity_o), .ev_level_o(ev_level_o));
  plc_load_model u_load (.pad_i(pad_o), .pad_oe_n_i(pad_oe_n_o), .pullup_en_i(pullup_en_o),
    .pin_lvl_o(pin_lvl));

  always #10 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      give_verdict;
    end
  end

  task give_verdict;
    begin
      if (mismatches == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input [55:0] seen, input [55:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      wr_data_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_sys_i);
      wr_i <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge clk_sys_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_sys_i);
      rd_i <= 1'b0;
      #1 d = rd_data_o;
    end
  endtask
  task sel(input integer pt, input integer pn);
    wr(8'h00, {1'b0, pt[2:0], 1'b0, pn[2:0]});
  endtask
  // one supply reset pulse, 1 selects standby
  task pulse(input sb);
    begin
      @(posedge clk_sys_i);
      vdd_rst_i <= !sb;
      vsb_rst_i <= sb;
      repeat (2) @(posedge clk_sys_i);
      vdd_rst_i <= 1'b0;
      vsb_rst_i <= 1'b0;
    end
  endtask
  function ok(input integer pt, input integer pn);
    ok = !(pt == 5 && pn > 5 || pt == 6 && pn > 4);
  endfunction
  function [7:0] rst_val(input integer pt, input integer pn);
    rst_val = ok(pt, pn) ? {1'b0, pt == 1 || pt == 4, 3'b000, PU_RST[pt*8+pn], 2'b00} : 8'h00;
  endfunction

  initial begin
    x = $urandom(32'h63d6);
    repeat (2) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_sys_i);
    #1 chk(pullup_en_o, PU_RST);
    pulse(1'b1);
    #1 chk(pullup_en_o[52], 1'b0);
    repeat (2) @(posedge clk_sys_i);
    #1 chk(pullup_en_o[52], 1'b1);
    for (p = 0; p < 7; p = p + 1)
      for (n = 0; n < 8; n = n + 1) begin
        sel(p, n);
        rd(8'h01);
        chk(d, rst_val(p, n));
      end
    repeat (60) begin
      p = $urandom % 7;
      n = $urandom % 8;
      w = $urandom & 8'hF7;
      sel(p, n);
      wr(8'h01, w);
      rd(8'h00);
      chk(d, {1'b0, p[2:0], 1'b0, n[2:0]});
      rd(8'h01);
      e = (p == 1 || p == 4) ? (w & 8'h77) : (w & 8'h07);
      chk(d, ok(p, n) ? e : 8'h00);
      i = p * 8 + n;
      k = (p == 4 ? 8 : 0) + n;
      if (ok(p, n)) begin
        chk(pad_oe_n_o[i], !w[0]);
        chk(pullup_en_o[i], w[2]);
        chk(pin_lvl[i], w[0] ? 1'b0 : w[2]);
      end
      if (p == 1 || p == 4)
        chk({ev_debounce_o[k], ev_polarity_o[k], ev_level_o[k]}, w[6:4]);
    end
    rd(8'h02);
    chk(d, 8'h00);
    wr(8'h12, 8'h08);
    sel(2, 3);
    wr(8'h01, 8'h03);
    rd(8'h01);
    chk({pad_o[19], pad_oe_n_o[19], pin_lvl[19]}, 3'b101);
    wr(8'h01, 8'h01);
    rd(8'h01);
    chk({pad_oe_n_o[19], pin_lvl[19]}, 2'b10);
    wr(8'h01, 8'h0B);
    wr(8'h12, 8'h00);
    wr(8'h01, 8'h04);
    wr(8'h03, 8'h70);
    rd(8'h01);
    chk(d, 8'h0B);
    chk(pad_o[19], 1'b1);
    rd(8'h12);
    chk(d, 8'h08);
    rd(8'h03);
    chk(d, 8'h00);
    wr(8'h04, 8'h02);
    rd(8'h04);
    chk(d, 8'h02);
    wr(8'h04, 8'h00);
    rd(8'h01);
    chk(d, 8'h03);
    for (x = 0; x < 2; x = x + 1) begin
      wr(8'h04, x[7:0]);
      wr(8'h01, 8'h0B);
      pulse(x == 0);
      rd(8'h01);
      chk(d, 8'h0B);
      pulse(x == 1);
      rd(8'h01);
      chk(d, 8'h03);
    end
    wr(8'h03, 8'hFF);
    rd(8'h03);
    chk(d, 8'h70);
    sel(1, 2);
    wr(8'h01, 8'h08);
    wr(8'h01, 8'h37);
    rd(8'h01);
    chk(d, 8'h38);
    chk({ev_debounce_o[2], ev_polarity_o[2], ev_level_o[2]}, 3'b011);
    sel(7, 0);
    rd(8'h01);
    chk(d, 8'h00);
    give_verdict;
  end
endmodule // tb_top
